// *** logic/pus_pkg.sv ***
// Purpose: Shared constants, states and carriers for the power-up sequencer.
// Assumes: 100 MHz system clock; Avalon-MM slave with 32-bit data and byte addresses.
// Notes:   Offsets are byte addresses of aligned words.
package pus_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned CLK_MHZ       = 100;
   localparam int unsigned INIT_US_SMALL = 100;
   localparam int unsigned INIT_US_MID   = 200;
   localparam int unsigned INIT_US_LARGE = 300;
   localparam int unsigned INIT_CYC_SMALL = INIT_US_SMALL * CLK_MHZ;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [3:0] REG_CTRL_OFS   = 4'h0;
   localparam logic [3:0] REG_STATUS_OFS = 4'h4;
   localparam logic [3:0] REG_INITCY_OFS = 4'h8;

   localparam int unsigned CTRL_PATTERN_BIT = 0;
   localparam int unsigned CTRL_PROGMODE_BIT = 1;
   localparam int unsigned STAT_STATE_LSB = 0;
   localparam int unsigned STAT_DONE_BIT  = 2;
   localparam int unsigned STAT_SUPPLY_BIT = 3;
   localparam logic [31:0] UNMAPPED_READ = 32'hdead_0000;

   localparam logic CTRL_PATTERN_RST  = 1'b0;
   localparam logic CTRL_PROGMODE_RST = 1'b0;

   // ****************************************
   // States
   // ****************************************
   typedef enum logic [1:0] {
      PUS_QUIESCENT = 2'b00,
      PUS_INIT      = 2'b01,
      PUS_ERASED    = 2'b10,
      PUS_USER      = 2'b11
   } pus_state_t;

   // Gating levels driven toward pins, array and test port
   typedef struct packed {
      logic pullUpEn;
      logic outputEn;
      logic inputEn;
      logic arrayEn;
      logic testPortEn;
   } pus_gate_t;

   localparam pus_gate_t GATE_OFF = '{pullUpEn: 1'b1, outputEn: 1'b0, inputEn: 1'b0,
                                      arrayEn: 1'b0, testPortEn: 1'b0};

endpackage

// *** logic/pus_init_timer.sv ***
// Purpose: Down-counter that times register initialization after supply is safe.
// Assumes: start is a one-cycle pulse; length is latched at start.
// Notes:   Reloading while busy restarts the count.
`timescale 1ns/1ps
module pus_init_timer
   import pus_pkg::*;
#(
   parameter int unsigned CNT_W = 20
) (
   input  wire logic             clk_sys,
   input  wire logic             reset,
   input  wire logic             start,
   input  wire logic             abort,
   input  wire logic [CNT_W-1:0] length,
   output logic                  done
);

   logic [CNT_W-1:0] count;
   logic             busy;

   always_ff @(posedge clk_sys) begin
      if (reset || abort) begin
         count <= '0;
         busy  <= 1'b0;
         done  <= 1'b0;
      end else if (start) begin
         count <= (length == '0) ? CNT_W'(1) : length;
         busy  <= 1'b1;
         done  <= 1'b0;
      end else if (busy) begin
         count <= count - CNT_W'(1);
         if (count == CNT_W'(1)) begin
            busy <= 1'b0;
            done <= 1'b1;
         end
      end else begin
         done <= 1'b0;
      end
   end

endmodule // pus_init_timer

// *** logic/powerup_state_sequencer.sv ***
// Purpose: Power-up sequencer: holds pins quiescent, times register init, then
//          enters erased or user operation and drives the pin and block gating.
// Assumes: supplySafe is synchronous to clk_sys and already debounced.
// Notes:   Software reaches control and status over Avalon-MM with waitrequest.
`timescale 1ns/1ps

// Contract
// - Without a safe core supply the block stays quiescent with pins and test port disabled.
// - While quiescent all output drivers are off and every pin pull-up is on.
// - Once the supply is safe the user registers are initialized over a timed interval.
// - When initialization ends the operating state is entered at once, with no outside action.
// - With no stored pattern outputs stay off, pull-ups stay on and the test port is enabled.
// - With a stored pattern pins take their configured states outside programming mode and the test port stays enabled.
// - Pull-ups are off in user operation and on in programming, power-up and erased state.
module powerup_state_sequencer
   import pus_pkg::*;
#(
   parameter int unsigned INIT_CYCLES = INIT_CYC_SMALL,
   parameter int unsigned PIN_COUNT   = 36,
   parameter int unsigned CNT_W       = 20
) (
   input  wire logic                 clk_sys,
   input  wire logic                 reset,
   // Supply monitor
   input  wire logic                 supplySafe,
   // Configured per-pin user behaviour, valid in user operation
   input  wire logic [PIN_COUNT-1:0] cfgOutputEn,
   // Gating outputs
   output logic [PIN_COUNT-1:0]      pinOutputEn,
   output logic [PIN_COUNT-1:0]      pinPullUpEn,
   output logic                      pinInputEn,
   output logic                      arrayEn,
   output logic                      testPortEn,
   output logic                      userRegInit,
   output pus_state_t                seqState,
   // Avalon-MM slave
   input  wire logic [3:0]           avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [31:0]          avs_writedata,
   output logic [31:0]               avs_readdata,
   output logic                      avs_waitrequest
);

   // ****************************************
   // Control registers
   // ****************************************
   logic             patternStored;
   logic             progMode;
   logic [CNT_W-1:0] initCycles;
   logic             initDone;
   logic             accDone;
   pus_state_t       state;
   pus_state_t       next_state;
   pus_gate_t        gate;
   logic             timerStart;
   logic             timerDone;

   wire logic accReq = (avs_read || avs_write) && !accDone;

   // One wait cycle per access: accept on the second edge, then drop the ack
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         accDone <= 1'b0;
      end else begin
         accDone <= accReq;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !accReq;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         patternStored <= CTRL_PATTERN_RST;
         progMode      <= CTRL_PROGMODE_RST;
         initCycles    <= CNT_W'(INIT_CYCLES);
      end else if (avs_write && !avs_waitrequest) begin
         case (avs_address)
            REG_CTRL_OFS: begin
               patternStored <= avs_writedata[CTRL_PATTERN_BIT];
               progMode      <= avs_writedata[CTRL_PROGMODE_BIT];
            end
            REG_INITCY_OFS: begin
               initCycles <= avs_writedata[CNT_W-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         avs_readdata <= '0;
      end else if (avs_read && accReq) begin
         case (avs_address)
            REG_CTRL_OFS: begin
               avs_readdata <= 32'(({progMode, patternStored}));
            end
            REG_STATUS_OFS: begin
               avs_readdata <= 32'({supplySafe, initDone, state});
            end
            REG_INITCY_OFS: begin
               avs_readdata <= 32'(initCycles);
            end
            default: begin
               avs_readdata <= UNMAPPED_READ;
            end
         endcase
      end
   end

   // ****************************************
   // Sequencer
   // ****************************************
   pus_init_timer #(
      .CNT_W (CNT_W)
   ) u_timer (
      .clk_sys (clk_sys),
      .reset   (reset),
      .start   (timerStart),
      .abort   (!supplySafe),
      .length  (initCycles),
      .done    (timerDone)
   );

   always_comb begin
      next_state = state;
      timerStart = 1'b0;
      case (state)
         PUS_QUIESCENT: begin
            if (supplySafe) begin
               next_state = PUS_INIT;
               timerStart = 1'b1;
            end
         end
         PUS_INIT: begin
            if (!supplySafe) begin
               next_state = PUS_QUIESCENT;
            end else if (timerDone) begin
               next_state = patternStored ? PUS_USER : PUS_ERASED;
            end
         end
         PUS_ERASED, PUS_USER: begin
            if (!supplySafe) begin
               next_state = PUS_QUIESCENT;
            end
         end
         default: begin
            next_state = PUS_QUIESCENT;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state <= PUS_QUIESCENT;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         initDone <= 1'b0;
      end else begin
         initDone <= (next_state == PUS_ERASED) || (next_state == PUS_USER);
      end
   end

   // ****************************************
   // Gating decode
   // ****************************************
   always_comb begin
      gate = GATE_OFF;
      case (state)
         // quiescent and init keep all but the pull-ups off
         PUS_QUIESCENT, PUS_INIT: begin
            gate = GATE_OFF;
         end
         // erased keeps pins off, test port on
         PUS_ERASED: begin
            gate.testPortEn = 1'b1;
         end
         PUS_USER: begin
            gate.testPortEn = 1'b1;
            gate.outputEn   = !progMode;
            gate.inputEn    = !progMode;
            gate.arrayEn    = !progMode;
            // pull-ups off only in valid operation
            gate.pullUpEn   = progMode;
         end
         default: begin
            gate = GATE_OFF;
         end
      endcase
   end

   genvar gi;
   generate
      for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
         always_ff @(posedge clk_sys) begin
            if (reset) begin
               pinOutputEn[gi] <= 1'b0;
               pinPullUpEn[gi] <= 1'b1;
            end else begin
               pinOutputEn[gi] <= gate.outputEn && cfgOutputEn[gi];
               pinPullUpEn[gi] <= gate.pullUpEn;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pinInputEn  <= 1'b0;
         arrayEn     <= 1'b0;
         testPortEn  <= 1'b0;
         userRegInit <= 1'b1;
         seqState    <= PUS_QUIESCENT;
      end else begin
         pinInputEn  <= gate.inputEn;
         arrayEn     <= gate.arrayEn;
         testPortEn  <= gate.testPortEn;
         // registers held in init until done
         userRegInit <= (state == PUS_QUIESCENT) || (state == PUS_INIT);
         seqState    <= state;
      end
   end

endmodule // powerup_state_sequencer

// *** testbench/pus_properties.sv ***
// Purpose: Port assertions for the power-up sequencer.
// Assumes: Bound to powerup_state_sequencer.
// Notes:   Gating is judged once a state has held two cycles, so output lag is tolerated.
`timescale 1ns/1ps
module pus_properties
   import pus_pkg::*;
#(
   parameter int unsigned INIT_CYCLES = 8,
   parameter int unsigned PIN_COUNT   = 36
) (
   input wire logic                 clk_sys,
   input wire logic                 reset,
   input wire logic                 supplySafe,
   input wire logic [PIN_COUNT-1:0] pinOutputEn,
   input wire logic [PIN_COUNT-1:0] pinPullUpEn,
   input wire logic                 pinInputEn,
   input wire logic                 arrayEn,
   input wire logic                 testPortEn,
   input wire pus_state_t           seqState
);
   localparam int INIT_HI = INIT_CYCLES + 2;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   quiet_pins_off_a: assert property (
      !seqState[1] && !$past(seqState[1]) |-> pinOutputEn == '0 && &pinPullUpEn)
      else $error("pins active while quiescent");
   quiet_port_off_a: assert property (
      !seqState[1] && !$past(seqState[1]) |-> !testPortEn && !pinInputEn && !arrayEn)
      else $error("port or array enabled while quiescent");
   erased_gate_a: assert property (
      seqState == PUS_ERASED && $past(seqState) == PUS_ERASED
      |-> pinOutputEn == '0 && &pinPullUpEn && testPortEn && !arrayEn)
      else $error("erased gating wrong");
   user_gate_a: assert property (
      seqState == PUS_USER && $past(seqState) == PUS_USER
      |-> testPortEn && pinInputEn == arrayEn && pinInputEn != pinPullUpEn[0]
          && (pinInputEn || pinOutputEn == '0))
      else $error("user gating wrong");
   supply_drop_a: assert property (
      !supplySafe |-> ##2 seqState == PUS_QUIESCENT)
      else $error("no return to quiescent");
   init_entry_a: assert property (
      seqState == PUS_QUIESCENT && supplySafe ##1 supplySafe |=> seqState == PUS_INIT)
      else $error("init not entered");
   init_bound_a: assert property (
      $rose(seqState == PUS_INIT) |-> ##[1:INIT_HI] (seqState[1] || !supplySafe))
      else $error("init too long");
   op_state_hold_a: assert property (
      seqState[1] && supplySafe |=> seqState == $past(seqState))
      else $error("operating state changed");
endmodule // pus_properties

bind powerup_state_sequencer pus_properties #(.INIT_CYCLES(INIT_CYCLES),
   .PIN_COUNT(PIN_COUNT)) i_pus_properties (.clk_sys, .reset, .supplySafe, .pinOutputEn,
   .pinPullUpEn, .pinInputEn, .arrayEn, .testPortEn, .seqState);

// *** testbench/pus_supply_model.sv ***
// Purpose: Core supply monitor model.
// Assumes: powerOn comes from the bench.
// Notes:   Safe flag lags power-on by a ramp and falls at once on power loss.
`timescale 1ns/1ps
module pus_supply_model #(
   parameter int unsigned RAMP = 3
) (
   input  wire logic clk_sys,
   input  wire logic powerOn,
   output logic      supplySafe
);
   int unsigned rampCnt = 0;
   initial supplySafe = 1'b0;
   always @(posedge clk_sys) begin
      if (!powerOn) begin
         rampCnt    <= 0;
         supplySafe <= 1'b0;
      end else if (rampCnt < RAMP) begin
         rampCnt <= rampCnt + 1;
      end else begin
         supplySafe <= 1'b1;
      end
   end
endmodule // pus_supply_model

// *** testbench/tb_top.sv ***
// Purpose: Self-checking bench for the power-up sequencer.
// Assumes: Init length shortened through INIT_CYCLES.
// Notes:   Pin config comes from an LFSR; pattern flag is 0, then 1, then LFSR bits.
`timescale 1ns/1ps
module tb_top;
   import pus_pkg::*;
   localparam int NI = 8;
   localparam int NP = 36;
   logic          clk_sys = 1'b0, reset = 1'b1, powerOn = 1'b0, supplySafe, pat;
   logic [NP-1:0] cfgOutputEn = '0, pinOutputEn, pinPullUpEn;
   logic          pinInputEn, arrayEn, testPortEn, userRegInit, avs_waitrequest;
   logic          avs_read = 1'b0, avs_write = 1'b0;
   logic [3:0]    avs_address = '0;
   logic [31:0]   avs_writedata = '0, avs_readdata, rd, lfsr = 32'h629f;
   pus_state_t    seqState, expState;
   int            error_cnt = 0, check_count = 0, cyc = 0, n;

   powerup_state_sequencer #(.INIT_CYCLES(NI), .PIN_COUNT(NP)) i_powerup_state_sequencer (
      .clk_sys, .reset, .supplySafe, .cfgOutputEn, .pinOutputEn, .pinPullUpEn, .pinInputEn,
      .arrayEn, .testPortEn, .userRegInit, .seqState, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_readdata, .avs_waitrequest);
   pus_supply_model #(.RAMP(3)) i_pus_supply_model (.clk_sys, .powerOn, .supplySafe);

   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   // Pin drivers then pull-ups
   function automatic logic [71:0] exp_pins(input pus_state_t s, input logic pm);
      if (s == PUS_USER && !pm) begin
         return {cfgOutputEn, {NP{1'b0}}};
      end
      return {{NP{1'b0}}, {NP{1'b1}}};
   endfunction
   task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic tally_and_finish();
      if (error_cnt == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      bus(1'b0, REG_CTRL_OFS, '0);
      check("ctrl reset", 72'(rd), 72'h0);
      bus(1'b0, REG_INITCY_OFS, '0);
      check("init length", 72'(rd), 72'(NI));
      bus(1'b0, 4'hc, '0);
      check("unmapped", 72'(rd), 72'(UNMAPPED_READ));
      check("reset pins", {pinOutputEn, pinPullUpEn}, exp_pins(PUS_QUIESCENT, 0));
      // Supply lost mid-init must abort back to quiescent
      powerOn <= 1'b1;
      while (seqState !== PUS_INIT) @(posedge clk_sys);
      repeat (3) @(posedge clk_sys);
      powerOn <= 1'b0;
      repeat (4) @(posedge clk_sys);
      check("abort", 72'(seqState), 72'(PUS_QUIESCENT));
      for (int k = 0; k < 4; k++) begin
         lfsr = lfsr_next(lfsr);
         pat = (k < 2) ? k[0] : lfsr[0];
         expState = pat ? PUS_USER : PUS_ERASED;
         cfgOutputEn <= {lfsr[3:0], lfsr};
         bus(1'b1, REG_CTRL_OFS, {31'h0, pat});
         powerOn <= 1'b1;
         while (seqState !== PUS_INIT) @(posedge clk_sys);
         n = 0;
         while (seqState === PUS_INIT) begin
            @(posedge clk_sys);
            n++;
         end
         check("init span", 72'(n >= NI - 1 && n <= NI + 2), 72'h1);
         check("op state", 72'(seqState), 72'(expState));
         check("reg init", 72'(userRegInit), 72'h0);
         check("gates op", 72'({testPortEn, pinInputEn, arrayEn}), 72'({1'b1, pat, pat}));
         bus(1'b1, REG_CTRL_OFS, {31'h0, !pat});
         check("state kept", 72'(seqState), 72'(expState));
         check("pins op", {pinOutputEn, pinPullUpEn}, exp_pins(expState, 0));
         bus(1'b1, REG_CTRL_OFS, {30'h0, 1'b1, pat});
         repeat (2) @(posedge clk_sys);
         check("pins prog", {pinOutputEn, pinPullUpEn}, exp_pins(expState, 1));
         bus(1'b0, REG_STATUS_OFS, '0);
         check("status", 72'(rd[3:0]), 72'({2'b11, expState}));
         powerOn <= 1'b0;
         repeat (4) @(posedge clk_sys);
         check("drop state", 72'(seqState), 72'(PUS_QUIESCENT));
         check("drop pins", {pinOutputEn, pinPullUpEn}, exp_pins(PUS_QUIESCENT, 0));
         check("drop gates", 72'({userRegInit, testPortEn, pinInputEn, arrayEn}), 72'h8);
      end
      tally_and_finish();
   end
endmodule // tb_top
